// File: dtc_pkg.sv
`default_nettype none
package dtc_pkg;

  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [1:0][7:0] DTC_BASE = {8'hea, 8'hca};
  localparam logic [7:0] DTC_OFS_CNT = 8'h00;
  localparam logic [7:0] DTC_OFS_CTL = 8'h01;
  localparam logic [7:0] DTC_OFS_CCTL0 = 8'h02;
  localparam logic [7:0] DTC_OFS_CC0 = 8'h03;
  localparam logic [7:0] DTC_OFS_CCTL1 = 8'h04;
  localparam logic [7:0] DTC_OFS_CC1 = 8'h05;
  localparam logic [7:0] DTC_ADDR_FLAGS = 8'hd8;
  localparam logic [7:0] DTC_ADDR_IEN = 8'hd9;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int DTC_CTL_DIV_LSB = 5;
  localparam int DTC_CTL_START = 4;
  localparam int DTC_CTL_OVERFLOW_IRQ_MASK = 3;
  localparam int DTC_CTL_CLR = 2;
  localparam int DTC_CCTL_IM = 6;
  localparam int DTC_CCTL_CMP_LSB = 3;
  localparam int DTC_CCTL_OE = 2;

  // ******************************************************
  // Encodings and reset values
  // ******************************************************
  localparam logic [1:0] DTC_MODE_FREE = 2'h0;
  localparam logic [1:0] DTC_MODE_DOWN = 2'h1;
  localparam logic [1:0] DTC_MODE_MOD = 2'h2;
  localparam logic [1:0] DTC_MODE_UPDN = 2'h3;
  localparam logic [2:0] DTC_ACT_SET = 3'h0;
  localparam logic [2:0] DTC_ACT_CLR = 3'h1;
  localparam logic [2:0] DTC_ACT_TGL = 3'h2;
  localparam logic [2:0] DTC_ACT_SETUP = 3'h3;
  localparam logic [2:0] DTC_ACT_CLRUP = 3'h4;
  localparam logic [2:0] DTC_ACT_SETFF = 3'h5;
  localparam logic [7:0] DTC_CTL_RST = 8'h08;
  localparam logic [6:0] DTC_CCTL_RST = 7'h40;
  localparam logic [4:0] DTC_IRQ_NUM_T3 = 5'h0b;
  localparam logic [4:0] DTC_IRQ_NUM_T4 = 5'h0c;

  // ******************************************************
  // Types
  // ******************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [6:0] presc;
    logic dir;
    logic [2:0] div;
    logic start;
    logic overflow_irq_mask;
    logic [1:0] mode;
    logic [7:0] cc0_buf;
    logic [7:0] cc0_act;
    logic [7:0] cc1;
    logic [1:0][6:0] cctl;
    logic [1:0] pin;
  } dtc_tmr_t;

  typedef struct packed {
    dtc_tmr_t [1:0] tmr;
    logic [5:0] flags;
    logic [1:0] ien;
    logic [1:0] cpuf;
    logic [1:0] irq;
    logic [7:0] rdata;
    logic [3:0] dma;
  } dtc_st_t;

  localparam dtc_tmr_t DTC_TMR_RST = '{cnt: 8'h00, presc: 7'h00, dir: 1'b0,
    div: DTC_CTL_RST[7:5], start: DTC_CTL_RST[4], overflow_irq_mask: DTC_CTL_RST[3], mode: DTC_CTL_RST[1:0],
    cc0_buf: 8'h00, cc0_act: 8'h00, cc1: 8'h00, cctl: {2{DTC_CCTL_RST}}, pin: 2'h0};
  localparam dtc_st_t DTC_ST_RST = '{tmr: {2{DTC_TMR_RST}}, flags: 6'h00, ien: 2'h0,
    cpuf: 2'h0, irq: 2'h0, rdata: 8'h00, dma: 4'h0};

endpackage : dtc_pkg
`default_nettype wire

// File: dtc_timer_pair.sv
// What this block does
// - Two timers, two compare pins each
// - 8-bit count steps only on active edges
// - Prescaler divides tick by 1 to 128
// - Count readable anytime, resets to zero
// - Clear bit zeroes counter, never stored
// - Start runs counter, stop freezes it
// - Free-run wraps 0xFF to zero, flags
// - Modulo counts to channel-0 value, flags
// - Down loads channel-0 value, holds zero
// - Up/down bounces between zero and top
// - Overflow raises CPU flag only if masked
// - Compare mode drives pin, compares running
// - Match sets, clears or toggles pin
// - Compare pins change glitch-free
// - Channel-0 value loads at zero; channel-1 immediate
// - Match sets channel flag; masked CPU flag
// - Up/down: channel-0 and overflow at zero
// - Flags set regardless of masks
// - Enabling mask on set flag requests again
// - One vector per timer, 11 and 12
// - Each channel pulses its DMA trigger
// - Mode codes: free, down, modulo, up/down
// - Prescale codes apply immediately
// - Action codes: set, clear, toggle, PWM
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_pair (
  input wire logic clock,
  input wire logic srst,
  input wire logic tick_en,
  input wire dtc_pkg::dtc_sfr_t sfr,
  output logic [7:0] sfr_rdata,
  output logic [3:0] cmp_pin_out,
  output logic [3:0] cmp_pin_oe,
  output logic dma_trig_t3c0,
  output logic dma_trig_t3c1,
  output logic dma_trig_t4c0,
  output logic dma_trig_t4c1,
  output logic [1:0] cpu_timer_flag,
  output logic [1:0] timer_irq_req
);

  dtc_pkg::dtc_st_t st_ff;
  dtc_pkg::dtc_st_t nxt_st;
  logic [1:0] tick_w;

  // ******************************************************
  // Prescaler edges
  // ******************************************************
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tick_w[t] = tick_en && ((st_ff.tmr[t].presc & (7'h7f >> (3'h7 - st_ff.tmr[t].div))) == 7'h00);
    end
  end

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    logic [7:0] cn;
    logic dn;
    logic ovf;
    logic [1:0] mt;
    logic [1:0] zf;
    logic [7:0] top;
    logic [7:0] cv;
    logic [2:0] act;
    logic [7:0] base;
    logic [5:0] setm;
    logic [7:0] rd;
    cn = 8'h00;
    dn = 1'b0;
    ovf = 1'b0;
    mt = 2'h0;
    zf = 2'h0;
    top = 8'h00;
    cv = 8'h00;
    act = 3'h0;
    base = 8'h00;
    setm = 6'h00;
    rd = 8'h00;
    nxt_st = st_ff;
    nxt_st.dma = 4'h0;
    for (int t = 0; t < 2; t++) begin
      base = dtc_pkg::DTC_BASE[t];
      top = st_ff.tmr[t].cc0_act;
      cn = st_ff.tmr[t].cnt;
      dn = st_ff.tmr[t].dir;
      ovf = 1'b0;
      mt = 2'h0;
      if (tick_en) begin
        nxt_st.tmr[t].presc = st_ff.tmr[t].presc + 7'h01;
      end
      if (st_ff.tmr[t].start && tick_w[t]) begin
        case (st_ff.tmr[t].mode)
          dtc_pkg::DTC_MODE_FREE: begin
            cn = st_ff.tmr[t].cnt + 8'h01;
            ovf = (cn == 8'hff);
          end
          dtc_pkg::DTC_MODE_DOWN: begin
            if (st_ff.tmr[t].cnt != 8'h00) begin
              cn = st_ff.tmr[t].cnt - 8'h01;
              ovf = (cn == 8'h00);
            end
          end
          dtc_pkg::DTC_MODE_MOD: begin
            cn = (st_ff.tmr[t].cnt >= top) ? 8'h00 : st_ff.tmr[t].cnt + 8'h01;
            ovf = (cn == top);
          end
          default: begin
            dn = st_ff.tmr[t].dir || (st_ff.tmr[t].cnt >= top);
            cn = dn ? ((st_ff.tmr[t].cnt == 8'h00) ? 8'h00 : st_ff.tmr[t].cnt - 8'h01) : st_ff.tmr[t].cnt + 8'h01;
            ovf = (cn == 8'h00);
            nxt_st.tmr[t].dir = (cn == 8'h00) ? 1'b0 : ((cn >= top) ? 1'b1 : dn);
          end
        endcase
        for (int c = 0; c < 2; c++) begin
          cv = (c == 0) ? top : st_ff.tmr[t].cc1;
          mt[c] = (cn == cv);
          act = st_ff.tmr[t].cctl[c][dtc_pkg::DTC_CCTL_CMP_LSB +: 3];
          if (st_ff.tmr[t].cctl[c][dtc_pkg::DTC_CCTL_OE]) begin
            case (act)
              dtc_pkg::DTC_ACT_SET: begin
                if (mt[c]) nxt_st.tmr[t].pin[c] = 1'b1;
              end
              dtc_pkg::DTC_ACT_CLR: begin
                if (mt[c]) nxt_st.tmr[t].pin[c] = 1'b0;
              end
              dtc_pkg::DTC_ACT_TGL: begin
                if (mt[c]) nxt_st.tmr[t].pin[c] = ~st_ff.tmr[t].pin[c];
              end
              dtc_pkg::DTC_ACT_SETUP, dtc_pkg::DTC_ACT_CLRUP: begin
                if (st_ff.tmr[t].mode == dtc_pkg::DTC_MODE_UPDN) begin
                  if (mt[c]) nxt_st.tmr[t].pin[c] = (act == dtc_pkg::DTC_ACT_SETUP) ^ dn;
                end else if (mt[c]) begin
                  nxt_st.tmr[t].pin[c] = (act == dtc_pkg::DTC_ACT_SETUP);
                end else if (cn == 8'h00) begin
                  nxt_st.tmr[t].pin[c] = (act != dtc_pkg::DTC_ACT_SETUP);
                end
              end
              dtc_pkg::DTC_ACT_SETFF: begin
                if (mt[c]) nxt_st.tmr[t].pin[c] = 1'b1;
                else if (cn == 8'hff) nxt_st.tmr[t].pin[c] = 1'b0;
              end
              default: begin
                nxt_st.tmr[t].pin[c] = st_ff.tmr[t].pin[c];
              end
            endcase
          end
        end
        nxt_st.tmr[t].cnt = cn;
      end
      zf[0] = (st_ff.tmr[t].mode == dtc_pkg::DTC_MODE_UPDN) ? ovf : mt[0];
      zf[1] = mt[1];
      setm[t*3 +: 3] = {zf[1], zf[0], ovf};
      nxt_st.dma[t*2 +: 2] = mt;
      if (sfr.wr) begin
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CTL) begin
          nxt_st.tmr[t].div = sfr.wdata[dtc_pkg::DTC_CTL_DIV_LSB +: 3];
          nxt_st.tmr[t].start = sfr.wdata[dtc_pkg::DTC_CTL_START];
          nxt_st.tmr[t].overflow_irq_mask = sfr.wdata[dtc_pkg::DTC_CTL_OVERFLOW_IRQ_MASK];
          nxt_st.tmr[t].mode = sfr.wdata[1:0];
          if (sfr.wdata[dtc_pkg::DTC_CTL_START] && !st_ff.tmr[t].start && sfr.wdata[1:0] == dtc_pkg::DTC_MODE_DOWN) begin
            nxt_st.tmr[t].cnt = st_ff.tmr[t].cc0_buf;
          end
          if (sfr.wdata[dtc_pkg::DTC_CTL_CLR]) begin
            nxt_st.tmr[t].cnt = 8'h00;
            nxt_st.tmr[t].dir = 1'b0;
          end
        end
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CCTL0) nxt_st.tmr[t].cctl[0] = sfr.wdata[6:0];
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CCTL1) nxt_st.tmr[t].cctl[1] = sfr.wdata[6:0];
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CC0) nxt_st.tmr[t].cc0_buf = sfr.wdata;
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CC1) nxt_st.tmr[t].cc1 = sfr.wdata;
      end
      if (st_ff.tmr[t].cnt == 8'h00) begin
        nxt_st.tmr[t].cc0_act = nxt_st.tmr[t].cc0_buf;
      end
      if (sfr.rd) begin
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CNT) rd = st_ff.tmr[t].cnt;
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CTL) begin
          rd = {st_ff.tmr[t].div, st_ff.tmr[t].start, st_ff.tmr[t].overflow_irq_mask, 1'b0, st_ff.tmr[t].mode};
        end
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CCTL0) rd = {1'b0, st_ff.tmr[t].cctl[0]};
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CCTL1) rd = {1'b0, st_ff.tmr[t].cctl[1]};
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CC0) rd = st_ff.tmr[t].cc0_buf;
        if (sfr.addr == base + dtc_pkg::DTC_OFS_CC1) rd = st_ff.tmr[t].cc1;
      end
    end
    // Flags: write zero clears, hardware set wins
    nxt_st.flags = st_ff.flags;
    if (sfr.wr && sfr.addr == dtc_pkg::DTC_ADDR_FLAGS) begin
      nxt_st.flags = st_ff.flags & sfr.wdata[5:0];
    end
    nxt_st.flags = nxt_st.flags | setm;
    if (sfr.wr && sfr.addr == dtc_pkg::DTC_ADDR_IEN) begin
      nxt_st.ien = sfr.wdata[1:0];
    end
    if (sfr.rd && sfr.addr == dtc_pkg::DTC_ADDR_FLAGS) rd = {2'h0, st_ff.flags};
    if (sfr.rd && sfr.addr == dtc_pkg::DTC_ADDR_IEN) rd = {6'h00, st_ff.ien};
    if (sfr.rd) nxt_st.rdata = rd;
    for (int t = 0; t < 2; t++) begin
      nxt_st.cpuf[t] = |(nxt_st.flags[t*3 +: 3] & {nxt_st.tmr[t].cctl[1][dtc_pkg::DTC_CCTL_IM],
        nxt_st.tmr[t].cctl[0][dtc_pkg::DTC_CCTL_IM], nxt_st.tmr[t].overflow_irq_mask});
      nxt_st.irq[t] = nxt_st.cpuf[t] && nxt_st.ien[t];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= dtc_pkg::DTC_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign sfr_rdata = st_ff.rdata;
  assign cmp_pin_out = {st_ff.tmr[1].pin, st_ff.tmr[0].pin};
  assign cmp_pin_oe = {st_ff.tmr[1].cctl[1][dtc_pkg::DTC_CCTL_OE], st_ff.tmr[1].cctl[0][dtc_pkg::DTC_CCTL_OE],
    st_ff.tmr[0].cctl[1][dtc_pkg::DTC_CCTL_OE], st_ff.tmr[0].cctl[0][dtc_pkg::DTC_CCTL_OE]};
  assign dma_trig_t3c0 = st_ff.dma[0];
  assign dma_trig_t3c1 = st_ff.dma[1];
  assign dma_trig_t4c0 = st_ff.dma[2];
  assign dma_trig_t4c1 = st_ff.dma[3];
  assign cpu_timer_flag = st_ff.cpuf;
  assign timer_irq_req = st_ff.irq;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (srst);

  logic wr_ctl0;
  logic wr_flags;
  assign wr_ctl0 = sfr.wr && sfr.addr == dtc_pkg::DTC_BASE[0] + dtc_pkg::DTC_OFS_CTL;
  assign wr_flags = sfr.wr && sfr.addr == dtc_pkg::DTC_ADDR_FLAGS;

  property p_hold_stopped;
    !st_ff.tmr[0].start && !wr_ctl0 |=> $stable(st_ff.tmr[0].cnt);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("Stopped counter moved");

  property p_free_step;
    st_ff.tmr[0].start && tick_w[0] && st_ff.tmr[0].mode == dtc_pkg::DTC_MODE_FREE && !wr_ctl0
      |=> st_ff.tmr[0].cnt == $past(st_ff.tmr[0].cnt) + 8'h01;
  endproperty
  a_free_step: assert property (p_free_step) else $error("Free count did not step by one");

  property p_no_tick_no_step;
    !tick_w[0] && !wr_ctl0 |=> st_ff.tmr[0].cnt == $past(st_ff.tmr[0].cnt);
  endproperty
  a_no_tick_no_step: assert property (p_no_tick_no_step) else $error("Count moved without edge");

  property p_clear;
    wr_ctl0 && sfr.wdata[dtc_pkg::DTC_CTL_CLR] |=> st_ff.tmr[0].cnt == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not zero counter");

  property p_free_wrap;
    st_ff.tmr[0].start && tick_w[0] && st_ff.tmr[0].mode == dtc_pkg::DTC_MODE_FREE
      && st_ff.tmr[0].cnt == 8'hfe && !wr_ctl0 && !wr_flags |=> st_ff.flags[0] && st_ff.tmr[0].cnt == 8'hff;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("Overflow flag missing at 0xFF");

  property p_down_hold;
    st_ff.tmr[0].start && st_ff.tmr[0].mode == dtc_pkg::DTC_MODE_DOWN && st_ff.tmr[0].cnt == 8'h00
      && !wr_ctl0 |=> st_ff.tmr[0].cnt == 8'h00;
  endproperty
  a_down_hold: assert property (p_down_hold) else $error("Down count left zero");

  property p_set_wins;
    wr_flags && sfr.wdata[1] == 1'b0 && st_ff.dma[0] == 1'b0 ##0 nxt_st.dma[0]
      && st_ff.tmr[0].mode != dtc_pkg::DTC_MODE_UPDN |=> st_ff.flags[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Clear beat a same-cycle set");

  property p_mask_rerequest;
    $rose(st_ff.tmr[0].overflow_irq_mask) && st_ff.flags[0] ##0 st_ff.ien[0] |-> timer_irq_req[0];
  endproperty
  a_mask_rerequest: assert property (p_mask_rerequest) else $error("Mask enable gave no request");

  property p_no_mask_no_flag;
    cpu_timer_flag[0] |-> |(st_ff.flags[2:0] & {st_ff.tmr[0].cctl[1][6], st_ff.tmr[0].cctl[0][6], st_ff.tmr[0].overflow_irq_mask});
  endproperty
  a_no_mask_no_flag: assert property (p_no_mask_no_flag) else $error("CPU flag without masked event");

  property p_cc1_now;
    sfr.wr && sfr.addr == dtc_pkg::DTC_BASE[0] + dtc_pkg::DTC_OFS_CC1 |=> st_ff.tmr[0].cc1 == $past(sfr.wdata);
  endproperty
  a_cc1_now: assert property (p_cc1_now) else $error("Channel-1 value not immediate");

  property p_cc0_defer;
    st_ff.tmr[0].cnt != 8'h00 |=> st_ff.tmr[0].cc0_act == $past(st_ff.tmr[0].cc0_act);
  endproperty
  a_cc0_defer: assert property (p_cc0_defer) else $error("Channel-0 value loaded off zero");

  property p_pin_set;
    dma_trig_t3c0 && $past(st_ff.tmr[0].cctl[0][5:2]) == 4'h1 |-> cmp_pin_out[0];
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("Set action left pin low");

  property p_mod_wrap;
    st_ff.tmr[0].start && tick_w[0] && st_ff.tmr[0].mode == dtc_pkg::DTC_MODE_MOD
      && st_ff.tmr[0].cnt >= st_ff.tmr[0].cc0_act && !wr_ctl0 |=> st_ff.tmr[0].cnt == 8'h00;
  endproperty
  a_mod_wrap: assert property (p_mod_wrap) else $error("Modulo count did not reload zero");

  property p_down_load;
    wr_ctl0 && sfr.wdata[dtc_pkg::DTC_CTL_START] && !st_ff.tmr[0].start && !sfr.wdata[dtc_pkg::DTC_CTL_CLR]
      && sfr.wdata[1:0] == dtc_pkg::DTC_MODE_DOWN |=> st_ff.tmr[0].cnt == $past(st_ff.tmr[0].cc0_buf);
  endproperty
  a_down_load: assert property (p_down_load) else $error("Down start did not load channel-0 value");

  property p_updn_turn;
    st_ff.tmr[0].start && tick_w[0] && st_ff.tmr[0].mode == dtc_pkg::DTC_MODE_UPDN && st_ff.tmr[0].dir
      && st_ff.tmr[0].cnt == 8'h01 && !wr_ctl0 && !wr_flags
      |=> st_ff.tmr[0].cnt == 8'h00 && st_ff.flags[1:0] == 2'h3;
  endproperty
  a_updn_turn: assert property (p_updn_turn) else $error("Zero turnaround flags missing");

  property p_clr_reads_zero;
    sfr.rd && sfr.addr == dtc_pkg::DTC_BASE[0] + dtc_pkg::DTC_OFS_CTL |=> !sfr_rdata[dtc_pkg::DTC_CTL_CLR];
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("Clear bit read back as one");

  property p_div1_every;
    tick_en && st_ff.tmr[0].div == 3'h0 |-> tick_w[0];
  endproperty
  a_div1_every: assert property (p_div1_every) else $error("Undivided tick gave no edge");

  property p_irq_gate;
    timer_irq_req[0] |-> cpu_timer_flag[0] && st_ff.ien[0];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Request without flag and enable");

  c_free_wrap: cover property (st_ff.tmr[0].cnt == 8'hff ##1 st_ff.tmr[0].cnt == 8'h00);
  c_updn_turn: cover property (st_ff.tmr[0].mode == dtc_pkg::DTC_MODE_UPDN && st_ff.tmr[0].dir ##1 !st_ff.tmr[0].dir);
  c_toggle: cover property ($changed(cmp_pin_out[1]));
  c_irq: cover property ($rose(timer_irq_req[1]));
  c_set_wins: cover property (wr_flags && nxt_st.dma[0]);

endmodule : dtc_timer_pair
`default_nettype wire

// File: dtc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************************
// Processor side: register bus master and pin pads
// ******************************************************
module dtc_cpu_model (
  input wire logic clock,
  input wire logic [7:0] sfr_rdata,
  input wire logic [3:0] cmp_pin_out,
  input wire logic [3:0] cmp_pin_oe,
  output var dtc_pkg::dtc_sfr_t sfr,
  output logic [3:0] pad
);
  logic [3:0] last_ff = 4'h0;

  initial sfr = '0;

  // Undriven pads show a changing level
  always @(posedge clock) begin
    last_ff <= pad;
  end
  assign pad = (cmp_pin_oe & cmp_pin_out) | (~cmp_pin_oe & ~last_ff);

  // One-cycle write strobe, launched off the falling edge
  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    sfr = '0;
  endtask : sfr_wr

  // Read data is registered one edge after the strobe
  task sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    sfr = '0;
    d = sfr_rdata;
  endtask : sfr_rd
endmodule : dtc_cpu_model
`default_nettype wire

// File: dtc_timer_pair_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_pair_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic tick_en = 1'b0;
  dtc_pkg::dtc_sfr_t sfr;
  logic [7:0] sfr_rdata;
  logic [3:0] cmp_pin_out;
  logic [3:0] cmp_pin_oe;
  logic [3:0] pad;
  logic d30, d31, d40, d41;
  logic [1:0] cpu_timer_flag;
  logic [1:0] timer_irq_req;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int dma1[2] = '{0, 0};
  int dma0[2] = '{0, 0};
  int n0;
  int m0;
  logic [2:0] acts[7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [6:0] pexp = 7'b1010101;
  localparam logic [7:0] FLG = dtc_pkg::DTC_ADDR_FLAGS;

  always #20 clock = ~clock;

  // ******************************************************
  // Design and processor model
  // ******************************************************
  dtc_timer_pair dtc_timer_pair_inst (
    .clock(clock), .srst(srst), .tick_en(tick_en), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .dma_trig_t3c0(d30), .dma_trig_t3c1(d31),
    .dma_trig_t4c0(d40), .dma_trig_t4c1(d41), .cpu_timer_flag(cpu_timer_flag),
    .timer_irq_req(timer_irq_req)
  );
  dtc_cpu_model dtc_cpu_model_inst (
    .clock(clock), .sfr_rdata(sfr_rdata), .cmp_pin_out(cmp_pin_out),
    .cmp_pin_oe(cmp_pin_oe), .sfr(sfr), .pad(pad)
  );

  // ******************************************************
  // Pulse counting and hang guard
  // ******************************************************
  always @(posedge clock) begin
    cycles++;
    if (d31 === 1'b1) dma1[0]++;
    if (d41 === 1'b1) dma1[1]++;
    if (d30 === 1'b1) dma0[0]++;
    if (d40 === 1'b1) dma0[1]++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic [7:0] ra(input int t, input logic [7:0] ofs);
    return dtc_pkg::DTC_BASE[t] + ofs;
  endfunction : ra

  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task chk2(input string nm, input logic [1:0] e, input logic [1:0] g);
    chk8(nm, {6'h00, e}, {6'h00, g});
  endtask : chk2

  task wr(input logic [7:0] a, input logic [7:0] d);
    dtc_cpu_model_inst.sfr_wr(a, d);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    dtc_cpu_model_inst.sfr_rd(a, d);
    chk8(nm, e, d);
  endtask : rd_chk

  task tick(input int n);
    @(negedge clock);
    tick_en = 1'b1;
    repeat (n) @(negedge clock);
    tick_en = 1'b0;
  endtask : tick

  task print_verdict();
    $display("Checks run %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ******************************************************
  // Tests
  // ******************************************************
  initial begin
    repeat (16) @(negedge clock);
    srst = 1'b0;
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h08, "ctl reset");
    rd_chk(ra(1, dtc_pkg::DTC_OFS_CCTL0), 8'h40, "cctl reset");
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h00, "count reset");
    rd_chk(8'hc0, 8'h00, "unmapped read");
    for (int d = 0; d < 8; d++) begin
      wr(ra(0, dtc_pkg::DTC_OFS_CTL), {3'(d), 5'h1c});
      tick(128);
      rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'(128 >> d), "prescaled count");
    end
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CTL), 8'hf8, "clear bit not kept");
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h1c);
    tick(7);
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h08);
    tick(9);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h07, "frozen count");
    wr(FLG, 8'h00);
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h14);
    tick(255);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'hff, "free count top");
    rd_chk(FLG, 8'h01, "overflow unmasked flag");
    chk2("cpu flag masked", 2'b00, cpu_timer_flag);
    wr(dtc_pkg::DTC_ADDR_IEN, 8'h01);
    chk2("irq masked", 2'b00, timer_irq_req);
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h18);
    chk2("cpu flag on mask", 2'b01, cpu_timer_flag);
    chk2("irq enabled", 2'b01, timer_irq_req);
    wr(dtc_pkg::DTC_ADDR_IEN, 8'h00);
    chk2("irq disabled", 2'b00, timer_irq_req);
    tick(1);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h00, "free wrap");
    wr(FLG, 8'h00);
    rd_chk(FLG, 8'h00, "flags cleared");
    chk2("cpu flag cleared", 2'b00, cpu_timer_flag);
    wr(dtc_pkg::DTC_ADDR_IEN, 8'h00);
    wr(ra(0, dtc_pkg::DTC_OFS_CC0), 8'h05);
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h1a);
    tick(5);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h05, "modulo top");
    rd_chk(FLG, 8'h03, "modulo flags");
    tick(4);
    wr(ra(0, dtc_pkg::DTC_OFS_CC0), 8'h02);
    tick(3);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h00, "old top kept");
    tick(3);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h00, "new top at zero");
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h08);
    wr(ra(0, dtc_pkg::DTC_OFS_CC0), 8'h03);
    wr(FLG, 8'h00);
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h19);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h03, "down load");
    tick(5);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h00, "down hold");
    rd_chk(FLG, 8'h05, "down flags");
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h08);
    wr(FLG, 8'h00);
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h1f);
    tick(4);
    rd_chk(ra(0, dtc_pkg::DTC_OFS_CNT), 8'h02, "updown falling");
    rd_chk(FLG, 8'h00, "no flag at top");
    tick(2);
    rd_chk(FLG, 8'h07, "updown zero flags");
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h08);
    wr(FLG, 8'h00);
    for (int t = 0; t < 2; t++) begin
      wr(ra(t, dtc_pkg::DTC_OFS_CCTL0), 8'h04);
      wr(ra(t, dtc_pkg::DTC_OFS_CC1), 8'h10);
      for (int a = 0; a < 7; a++) begin
        wr(ra(t, dtc_pkg::DTC_OFS_CCTL1), {2'b00, acts[a], 3'b100});
        wr(ra(t, dtc_pkg::DTC_OFS_CTL), 8'h1c);
        n0 = dma1[t];
        m0 = dma0[t];
        tick(16);
        wr(ra(t, dtc_pkg::DTC_OFS_CTL), 8'h08);
        chk8("pin level", {7'h00, pexp[a]}, {7'h00, pad[2*t+1]});
        chk8("pin driven", 8'h01, {7'h00, cmp_pin_oe[2*t+1]});
        chk8("dma pulses", 8'h01, 8'(dma1[t] - n0));
        chk8("ch0 dma pulses", (t == 0) ? 8'h01 : 8'h00, 8'(dma0[t] - m0));
      end
      chk8("ch0 pin level", (t == 0) ? 8'h01 : 8'h00, {7'h00, pad[2*t]});
      rd_chk(FLG, (t == 0) ? 8'h06 : 8'h20, "channel flags");
      chk2("cpu flag unmasked", 2'b00, cpu_timer_flag);
      wr(ra(t, dtc_pkg::DTC_OFS_CCTL1), 8'h5c);
      chk2("cpu flag per timer", (t == 0) ? 2'b01 : 2'b10, cpu_timer_flag);
      wr(FLG, 8'h00);
      chk2("cpu flag after clear", 2'b00, cpu_timer_flag);
    end
    // Match lands on the same edge as a clearing write
    wr(ra(0, dtc_pkg::DTC_OFS_CC0), 8'h02);
    tick_en = 1'b1;
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h1c);
    wr(FLG, 8'h00);
    rd_chk(FLG, 8'h02, "set beats clear");
    tick_en = 1'b0;
    wr(ra(0, dtc_pkg::DTC_OFS_CTL), 8'h08);
    print_verdict();
  end
endmodule : dtc_timer_pair_bench
`default_nettype wire
